// *** rtl/flpc_lock_call.sv ***
// flash protection level decode and service call dispatch
`include "flpc_params.svh"
// Notes on behaviour
// - three protection bits, each FFh erased and 00h programmed.
// - only chip erase or reset returns the bits to FFh.
// - level 2 refuses all serial-port programming, signature and fuses too.
// - level 3 also blocks serial code and data reads; signatures, fuses readable.
// - levels restrict the serial port and, at level 4, external fetch; never boot ROM or firmware.
// - bits at 00h,01h,02h decode to levels one to four.
// - level 4 blocks external execution above 32K when boot select is 1.
// - service chosen by registers, dispatched through entry FFF0h.
// - boot ROM mapped while the map enable bit is set.
// - services leave interrupt enables untouched; firmware masks them.
// - selector 00h returns identification byte chosen by first pointer.
module flpc_lock_call
  import flpc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] DEV_ID1 = 8'h11, // arbitrary value
  parameter logic [7:0] DEV_ID2 = 8'h22, // arbitrary value
  parameter logic [7:0] DEV_ID3 = 8'h33 // arbitrary value
)
(
  input wire logic clk,
  input wire logic rst_n,
  // serial programming port requests
  input wire logic isp_program_req,
  input wire logic [1:0] isp_program_space,
  input wire logic isp_read_req,
  input wire logic [1:0] isp_read_space,
  input wire logic isp_lock_program,
  input wire logic [1:0] isp_lock_addr,
  input wire logic chip_erase,
  // firmware and boot ROM requests
  input wire logic iap_program_req,
  // fetch check
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_external,
  input wire logic boot_memory_select,
  // service call
  input wire logic boot_rom_map_enable,
  input wire logic call_strobe,
  input wire logic [15:0] call_target,
  input wire logic [7:0] working_register_one,
  input wire logic [7:0] accumulator,
  input wire logic [15:0] first_data_pointer,
  input wire logic [15:0] second_data_pointer,
  // answers
  output logic [3:0] protection_level,
  output logic [23:0] lock_bits,
  output logic isp_program_grant,
  output logic isp_program_refused,
  output logic isp_read_grant,
  output logic isp_read_refused,
  output logic iap_program_grant,
  output logic fetch_blocked,
  output logic boot_rom_mapped,
  output logic call_done,
  output logic call_unknown,
  output logic [7:0] result_accumulator
);
  // space codes: 0 code, 1 data, 2 user signature, 3 fuses (maker signature read as 2)
  localparam logic [1:0] SPACE_SIGN = 2'h2;
  localparam logic [1:0] SPACE_FUSE = 2'h3;

  logic [7:0] bit0;
  logic [7:0] bit1;
  logic [7:0] bit2;
  flpc_level_t level;
  flpc_state_t state;
  logic [7:0] sel;
  logic [15:0] ptr;
  logic call_hit;
  logic sign_read;

  // ==========================================================
  // protection bits
  flpc_lock_bit u_bit0 (.clk(clk), .rst_n(rst_n), .chip_erase(chip_erase),
    .program_bit(isp_lock_program && isp_lock_addr == `FLPC_LOCK_ADDR0), .value(bit0));
  flpc_lock_bit u_bit1 (.clk(clk), .rst_n(rst_n), .chip_erase(chip_erase),
    .program_bit(isp_lock_program && isp_lock_addr == `FLPC_LOCK_ADDR1), .value(bit1));
  flpc_lock_bit u_bit2 (.clk(clk), .rst_n(rst_n), .chip_erase(chip_erase),
    .program_bit(isp_lock_program && isp_lock_addr == `FLPC_LOCK_ADDR2), .value(bit2));
  assign lock_bits = {bit2, bit1, bit0};

  // ==========================================================
  // level decode; odd combinations fall to the weakest level implied, set by the lowest erased bit
  always_comb begin
    if (bit0 == `FLPC_BIT_ERASED) begin
      level = FLPC_LEVEL1;
    end else if (bit1 == `FLPC_BIT_ERASED) begin
      level = FLPC_LEVEL2;
    end else if (bit2 == `FLPC_BIT_ERASED) begin
      level = FLPC_LEVEL3;
    end else begin
      level = FLPC_LEVEL4;
    end
  end
  assign protection_level = level;

  // ==========================================================
  // serial port gating; firmware path never looks at the level
  assign sign_read = isp_read_space == SPACE_SIGN || isp_read_space == SPACE_FUSE;
  assign isp_program_refused = isp_program_req && level != FLPC_LEVEL1;
  assign isp_program_grant = isp_program_req && level == FLPC_LEVEL1;
  assign isp_read_refused = isp_read_req && !sign_read
    && (level == FLPC_LEVEL3 || level == FLPC_LEVEL4);
  assign isp_read_grant = isp_read_req && !isp_read_refused;
  assign iap_program_grant = iap_program_req;
  assign fetch_blocked = level == FLPC_LEVEL4 && boot_memory_select && fetch_external
    && fetch_addr >= `FLPC_EXT_LIMIT;

  // ==========================================================
  // service call: taken only at the entry with boot ROM mapped
  assign boot_rom_mapped = boot_rom_map_enable;
  assign call_hit = call_strobe && boot_rom_map_enable && call_target == `FLPC_ENTRY_ADDR;

  // capture selector and pointer, answer two cycles later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= FLPC_IDLE;
      sel <= 8'h00;
      ptr <= 16'h0000;
    end else begin
      case (state)
        FLPC_IDLE: begin
          if (call_hit) begin
            state <= FLPC_BUSY;
            sel <= working_register_one;
            ptr <= first_data_pointer;
          end
        end
        FLPC_BUSY: begin
          state <= FLPC_DONE;
        end
        default: begin
          state <= FLPC_IDLE;
        end
      endcase
    end
  end

  // identification answer; other selectors keep the accumulator
  always_ff @(posedge clk or negedge rst_n) begin // writes the answer and the done and unknown flags, never interrupt enables
    if (!rst_n) begin
      result_accumulator <= 8'h00;
      call_done <= 1'b0;
      call_unknown <= 1'b0;
    end else begin
      call_done <= state == FLPC_BUSY;
      call_unknown <= 1'b0;
      if (state == FLPC_BUSY) begin
        if (sel != `FLPC_SEL_IDENT) begin
          result_accumulator <= accumulator;
          call_unknown <= 1'b1;
        end else if (ptr == `FLPC_ID_MAKER) begin
          result_accumulator <= MAKER_ID;
        end else if (ptr == `FLPC_ID_DEV1) begin
          result_accumulator <= DEV_ID1;
        end else if (ptr == `FLPC_ID_DEV2) begin
          result_accumulator <= DEV_ID2;
        end else if (ptr == `FLPC_ID_DEV3) begin
          result_accumulator <= DEV_ID3;
        end else begin
          result_accumulator <= accumulator;
          call_unknown <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // checks
  AST_LEVEL2_NO_PROG: assert property (@(posedge clk) disable iff (!rst_n)
    (isp_program_req && bit0 == 8'h00) |-> !isp_program_grant && isp_program_refused)
    else $error("serial programming granted while locked");
  AST_LEVEL1_PROG: assert property (@(posedge clk) disable iff (!rst_n)
    (isp_program_req && bit0 == `FLPC_BIT_ERASED) |-> isp_program_grant && !isp_program_refused)
    else $error("serial programming refused while unlocked");
  // signature and fuse spaces get no exemption from the programming lock
  AST_SPACE_PROG_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
    (isp_program_req && isp_program_space >= SPACE_SIGN && bit0 == `FLPC_BIT_PROGRAMMED)
    |-> isp_program_refused)
    else $error("signature or fuse programming granted while locked");
  AST_LEVEL3_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (isp_read_req && bit0 == 8'h00 && bit1 == 8'h00 && !sign_read) |-> !isp_read_grant)
    else $error("serial read granted at level three");
  AST_SIGN_READ: assert property (@(posedge clk) disable iff (!rst_n)
    (isp_read_req && sign_read) |-> isp_read_grant)
    else $error("signature read refused");
  AST_IAP_FREE: assert property (@(posedge clk) disable iff (!rst_n)
    iap_program_req |-> iap_program_grant)
    else $error("firmware programming blocked");
  AST_ONLY_ERASE: assert property (@(posedge clk) disable iff (!rst_n)
    (bit0 == 8'h00 && !chip_erase) |=> bit0 == 8'h00)
    else $error("lock bit cleared without chip erase");
  AST_ERASE_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    chip_erase |=> lock_bits == 24'hffffff && protection_level == 4'b0001)
    else $error("chip erase left lock bits");
  AST_LEVEL3_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
    lock_bits == 24'hff0000 |-> protection_level == 4'b0100)
    else $error("two programmed bits not decoded as level three");
  AST_LEVEL4_FETCH: assert property (@(posedge clk) disable iff (!rst_n)
    (lock_bits == 24'h000000 && boot_memory_select && fetch_external && fetch_addr[15])
    |-> fetch_blocked)
    else $error("external fetch above 32K not blocked");
  AST_FETCH_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    fetch_addr < `FLPC_EXT_LIMIT |-> !fetch_blocked)
    else $error("fetch below 32K blocked");
  AST_CALL_TIMING: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FLPC_IDLE && call_hit) |-> !call_done ##1 !call_done ##1 call_done)
    else $error("service answer not two cycles after entry");
  AST_MAKER_ID: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FLPC_IDLE && call_hit && working_register_one == 8'h00 && first_data_pointer == 16'h0000)
    |-> ##2 result_accumulator == MAKER_ID)
    else $error("maker code not returned");
  AST_UNKNOWN_SEL: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FLPC_IDLE && call_hit && working_register_one != `FLPC_SEL_IDENT) |-> ##2 call_unknown)
    else $error("non identification selector not flagged");
  AST_NO_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    (state == FLPC_IDLE && !boot_rom_map_enable) |=> state == FLPC_IDLE)
    else $error("call taken with boot ROM unmapped");
endmodule

// *** rtl/flpc_params.svh ***
// constants for the flash lock and service call block
`ifndef FLPC_PARAMS_SVH
`define FLPC_PARAMS_SVH
`define FLPC_BIT_ERASED 8'hff
`define FLPC_BIT_PROGRAMMED 8'h00
`define FLPC_LOCK_ADDR0 2'h0
`define FLPC_LOCK_ADDR1 2'h1
`define FLPC_LOCK_ADDR2 2'h2
`define FLPC_ENTRY_ADDR 16'hfff0
`define FLPC_EXT_LIMIT 16'h8000
`define FLPC_SEL_IDENT 8'h00
`define FLPC_ID_MAKER 16'h0000
`define FLPC_ID_DEV1 16'h0001
`define FLPC_ID_DEV2 16'h0002
`define FLPC_ID_DEV3 16'h0003
`endif

// *** rtl/flpc_pkg.sv ***
// types for the flash lock and service call block
package flpc_pkg;
  typedef enum logic [3:0] {
    FLPC_LEVEL1 = 4'b0001,
    FLPC_LEVEL2 = 4'b0010,
    FLPC_LEVEL3 = 4'b0100,
    FLPC_LEVEL4 = 4'b1000
  } flpc_level_t;
  typedef enum logic [2:0] {
    FLPC_IDLE = 3'b001,
    FLPC_BUSY = 3'b010,
    FLPC_DONE = 3'b100
  } flpc_state_t;
endpackage

// *** rtl/flpc_lock_bit.sv ***
// one nonvolatile protection bit cell
`include "flpc_params.svh"
module flpc_lock_bit
  import flpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic program_bit,
  input wire logic chip_erase,
  output logic [7:0] value
);
  // cell loads erased at reset; only reset or chip erase returns it, and erase wins over program
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= `FLPC_BIT_ERASED;
    end else if (chip_erase) begin
      value <= `FLPC_BIT_ERASED;
    end else if (program_bit) begin
      value <= `FLPC_BIT_PROGRAMMED;
    end
  end
endmodule

// *** testbench/flpc_far_model.sv ***
// far-side model of the serial programmer
module flpc_far_model (
  input wire logic clk,
  output logic isp_program_req,
  output logic [1:0] isp_program_space,
  output logic isp_read_req,
  output logic [1:0] isp_read_space,
  output logic isp_lock_program,
  output logic [1:0] isp_lock_addr,
  output logic chip_erase
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fuses_done = 1'b0;
  initial {isp_program_req, isp_program_space, isp_read_req, isp_read_space} = 6'h0;
  initial {isp_lock_program, isp_lock_addr, chip_erase} = 4'h0;
  // one request raised just after a falling edge, held until idle
  task automatic req(input logic prog, input logic [1:0] sp);
    @(negedge clk);
    isp_program_req <= prog;
    isp_read_req <= !prog;
    isp_program_space <= sp;
    isp_read_space <= sp;
  endtask
  // released space lines show the inverse so stale values cannot pass
  task automatic idle;
    @(negedge clk);
    {isp_program_req, isp_read_req} <= 2'h0;
    isp_program_space <= ~isp_program_space;
    isp_read_space <= ~isp_read_space;
  endtask
  // one-cycle lock or erase pulse; fuses are written before any lock
  task automatic lock(input logic [1:0] a, input logic erase);
    if (!fuses_done && !erase) begin
      req(1'b1, 2'h3);
      idle();
      fuses_done = 1'b1;
    end
    if (erase) fuses_done = 1'b0;
    @(negedge clk);
    isp_lock_addr <= a;
    isp_lock_program <= !erase;
    chip_erase <= erase;
    @(negedge clk);
    {isp_lock_program, chip_erase} <= 2'h0;
    isp_lock_addr <= ~a;
  endtask
endmodule

// *** testbench/tb_flpc_lock_call.sv ***
// self-checking bench for the flash lock and service call block
`include "flpc_params.svh"
module tb_flpc_lock_call import flpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic isp_program_req, isp_read_req, isp_lock_program, chip_erase, iap_program_req, fetch_external;
  logic boot_memory_select, boot_rom_map_enable, call_strobe, call_done, call_unknown, fetch_blocked;
  logic isp_program_grant, isp_program_refused, isp_read_grant, isp_read_refused, iap_program_grant;
  logic boot_rom_mapped;
  logic [1:0] isp_program_space, isp_read_space, isp_lock_addr;
  logic [7:0] working_register_one, accumulator, result_accumulator;
  logic [15:0] fetch_addr, call_target, first_data_pointer, second_data_pointer;
  logic [3:0] protection_level;
  logic [23:0] lock_bits;
  logic [7:0] ids [4] = '{8'h5a, 8'h11, 8'h22, 8'h33}; // arbitrary, match the defaults
  int err_count = 0;
  int cmp_count = 0;
  flpc_far_model flpc_far_model_i (.clk, .isp_program_req, .isp_program_space, .isp_read_req,
    .isp_read_space, .isp_lock_program, .isp_lock_addr, .chip_erase);
  flpc_lock_call flpc_lock_call_i (.clk, .rst_n, .isp_program_req, .isp_program_space, .isp_read_req,
    .isp_read_space, .isp_lock_program, .isp_lock_addr, .chip_erase, .iap_program_req, .fetch_addr,
    .fetch_external, .boot_memory_select, .boot_rom_map_enable, .call_strobe, .call_target,
    .working_register_one, .accumulator, .first_data_pointer, .second_data_pointer, .protection_level,
    .lock_bits, .isp_program_grant, .isp_program_refused, .isp_read_grant, .isp_read_refused,
    .iap_program_grant, .fetch_blocked, .boot_rom_mapped, .call_done, .call_unknown, .result_accumulator);
  // ==========================================
  // clock, checks and closing
  initial forever #5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // expected bit bytes for n programmed bits, lowest address first
  function automatic logic [23:0] want_bits(input int n);
    for (int i = 0; i < 3; i++) want_bits[8*i+:8] = (i < n) ? 8'h00 : 8'hff;
  endfunction
  // ==========================================
  // serial gating, firmware exemption and fetch check at n programmed bits
  task automatic gates(input int n);
    logic ok;
    check({protection_level, lock_bits}, {4'h1 << n, want_bits(n)});
    flpc_far_model_i.req(1'b1, 2'(n)); // levels three and four try signature and fuse spaces
    iap_program_req = 1'b1;
    #2 check({isp_program_grant, isp_program_refused, iap_program_grant}, {n == 0, n != 0, 1'b1});
    for (int sp = 0; sp < 4; sp++) begin
      flpc_far_model_i.req(1'b0, 2'(sp));
      ok = n < 2 || sp >= 2;
      #2 check({isp_read_grant, isp_read_refused}, {ok, !ok});
    end
    flpc_far_model_i.idle();
    iap_program_req = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {fetch_external, boot_memory_select, fetch_addr} = i < 2 ? {2'h3, 16'h7fff + 16'(i)} : 18'($urandom);
      #2 check(fetch_blocked, n == 3 && fetch_external && boot_memory_select && fetch_addr > 16'h7fff);
    end
  endtask
  // ==========================================
  // service call with bounded wait for the answer
  task automatic call(input logic [7:0] sel, input logic [15:0] ptr, input logic map, input logic [15:0] tgt);
    logic [7:0] acc;
    logic id;
    int k;
    acc = 8'($urandom);
    id = sel == 8'h00 && ptr < 16'h0004;
    @(negedge clk);
    // one strobe stands for a long call from firmware that fed the watchdog and kept stack room
    {boot_rom_map_enable, call_target, working_register_one, accumulator} = {map, tgt, sel, acc};
    {first_data_pointer, second_data_pointer, call_strobe} = {ptr, 16'($urandom), 1'b1};
    @(negedge clk);
    call_strobe = 1'b0;
    check(boot_rom_mapped, map);
    k = 0;
    while (call_done !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    // done rises after the second edge from the strobe: one falling edge after the first look
    check({call_done, k == 1}, {2{map && tgt == `FLPC_ENTRY_ADDR}});
    if (k == 1) check({call_unknown, result_accumulator}, {!id, id ? ids[ptr[1:0]] : acc});
  endtask
  initial begin
    {iap_program_req, fetch_external, boot_memory_select, call_strobe} = 4'h0;
    {boot_rom_map_enable, fetch_addr, call_target, working_register_one, accumulator} = 49'h0;
    {first_data_pointer, second_data_pointer} = 32'h0;
    void'($urandom(32'h67ef));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    flpc_far_model_i.lock(2'h3, 1'b0);
    for (int n = 0; n < 4; n++) begin
      if (n > 0) flpc_far_model_i.lock(2'(n - 1), 1'b0);
      gates(n);
    end
    flpc_far_model_i.lock(2'h0, 1'b1);
    #2 check(lock_bits, 24'hffffff);
    for (int i = 0; i < 5; i++) call(8'h00, 16'(i), 1'b1, `FLPC_ENTRY_ADDR);
    call(8'h01, 16'h0000, 1'b1, `FLPC_ENTRY_ADDR);
    call(8'h00, 16'h0001, 1'b0, `FLPC_ENTRY_ADDR);
    call(8'h00, 16'h0002, 1'b1, 16'hfff3);
    repeat (6) call(8'($urandom_range(1)), 16'($urandom_range(5)), 1'b1, `FLPC_ENTRY_ADDR);
    tally_and_finish();
  end
  // watchdog: the run needs well under 2000 cycles
  initial begin
    #50us;
    err_count++;
    tally_and_finish();
  end
endmodule
